// ===== acpc_apb_host.sv
`timescale 1ns/1ps
`default_nettype none
module acpc_apb_host (
  input wire logic mclk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h0;
    pwdata_o = 32'h0;
  end
  // Bounded wait so a stalled slave ends as a timeout, not a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic tmo);
    @(posedge mclk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    tmo = 1'b1;
    for (int i = 0; i < 16 && tmo; i++) begin
      @(posedge mclk_i);
      tmo = (pready_i !== 1'b1);
    end
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
endmodule : acpc_apb_host
`default_nettype wire

// ===== acpc_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module acpc_clkdiv
  import acpc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  acpc_tick_if.src tk
);
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } acpc_div_st_t;
  acpc_div_st_t s_reg, s_next;
  logic [5:0] lim;
  always_comb begin
    // Code 111 is undefined; treated as the slowest rate
    lim = (tk.div_sel == 3'h7) ? ACPC_DIV_MAX_LIM : 6'((7'h1 << tk.div_sel) - 7'h1);
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (tk.clr) begin
      s_next.cnt = 6'h0;
    end else if (s_reg.cnt >= lim) begin
      s_next.cnt = 6'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 6'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign tk.tick = s_reg.tick;
endmodule : acpc_clkdiv
`default_nettype wire

// ===== acpc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module acpc_ctrl
  import acpc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [9:0] analog_input_channels_o,
  output logic [9:0] pin_func_disable_o,
  output logic [9:0] pull_high_disable_o,
  output logic [9:0] dir_override_o,
  output logic converter_power_on_o,
  output logic converter_reset_o,
  output logic conv_clk_en_o,
  output logic conversion_busy_o,
  output logic reference_ext_o,
  output logic vref_pin_func_disable_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] sel_low;
    logic [1:0] sel_high;
    logic start;
    logic busy;
    logic poff;
    logic vref;
    logic [2:0] div;
    logic irqf;
    logic irqe;
    acpc_state_t st;
    logic [4:0] ticks;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [9:0] ain;
    logic conv_rst;
    logic cen;
    logic irq;
    logic pwr_on;
    logic ref_ext;
  } acpc_st_t;
  acpc_st_t s_reg, s_next;
  acpc_tick_if tk();
  acpc_clkdiv u_div (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .tk(tk.src)
  );
  logic [9:0] sel;
  logic wr;
  logic rd;
  logic hit;
  assign sel = {s_reg.sel_high, s_reg.sel_low};
  // One wait state: answer comes in the cycle after the access phase begins
  assign wr = psel_i && penable_i && pwrite_i && !s_reg.ready;
  assign rd = psel_i && penable_i && !pwrite_i && !s_reg.ready;
  assign hit = (paddr_i == ACPC_OFS_CTRL_FIRST) || (paddr_i == ACPC_OFS_CTRL_SECOND) ||
               (paddr_i == ACPC_OFS_SEL_LOW) || (paddr_i == ACPC_OFS_SEL_HIGH) ||
               (paddr_i == ACPC_OFS_IRQ);
  always_comb begin
    s_next = s_reg;
    s_next.ready = psel_i && penable_i && !s_reg.ready;
    s_next.err = (wr || rd) && !hit;
    s_next.rdata = 32'h0;
    if (rd) begin
      case (paddr_i)
        ACPC_OFS_CTRL_FIRST: begin
          s_next.rdata[ACPC_START_POS] = s_reg.start;
          s_next.rdata[ACPC_BUSY_POS] = s_reg.busy;
          s_next.rdata[ACPC_POFF_POS] = s_reg.poff;
        end
        ACPC_OFS_CTRL_SECOND: begin
          s_next.rdata[ACPC_VREF_POS] = s_reg.vref;
          s_next.rdata[ACPC_DIV_LSB +: 3] = s_reg.div;
        end
        ACPC_OFS_SEL_LOW: s_next.rdata[7:0] = s_reg.sel_low;
        ACPC_OFS_SEL_HIGH: s_next.rdata[1:0] = s_reg.sel_high;
        ACPC_OFS_IRQ: begin
          s_next.rdata[ACPC_IRQF_POS] = s_reg.irqf;
          s_next.rdata[ACPC_IRQE_POS] = s_reg.irqe;
        end
        default: s_next.rdata = 32'h0;
      endcase
    end
    if (wr) begin
      case (paddr_i)
        ACPC_OFS_CTRL_FIRST: begin
          s_next.start = pwdata_i[ACPC_START_POS];
          s_next.poff = pwdata_i[ACPC_POFF_POS];
        end
        ACPC_OFS_CTRL_SECOND: begin
          s_next.vref = pwdata_i[ACPC_VREF_POS];
          s_next.div = pwdata_i[ACPC_DIV_LSB +: 3];
        end
        ACPC_OFS_SEL_LOW: s_next.sel_low = pwdata_i[7:0];
        ACPC_OFS_SEL_HIGH: s_next.sel_high = pwdata_i[1:0];
        ACPC_OFS_IRQ: begin
          // Write one to clear the request flag
          if (pwdata_i[ACPC_IRQF_POS]) begin
            s_next.irqf = 1'b0;
          end
          s_next.irqe = pwdata_i[ACPC_IRQE_POS];
        end
        default: s_next.err = 1'b1;
      endcase
    end
    // Sequencer follows the committed start level
    case (s_reg.st)
      ACPC_IDLE: begin
        if (s_reg.start) begin
          s_next.st = ACPC_HOLD;
          s_next.busy = 1'b1;
        end
      end
      ACPC_HOLD: begin
        // Held in reset until start drops again
        if (!s_reg.start && !s_reg.poff) begin
          s_next.st = ACPC_RUN;
          s_next.ticks = 5'h0;
        end else if (!s_reg.start) begin
          s_next.st = ACPC_IDLE;
        end
      end
      ACPC_RUN: begin
        if (s_reg.start) begin
          s_next.st = ACPC_HOLD;
        end else if (s_reg.poff) begin
          s_next.st = ACPC_IDLE;
        end else if (tk.tick) begin
          if (s_reg.ticks == ACPC_CONV_TICKS - 5'h1) begin
            s_next.st = ACPC_IDLE;
            s_next.busy = 1'b0;
            s_next.irqf = 1'b1;
          end else begin
            s_next.ticks = s_reg.ticks + 5'h1;
          end
        end
      end
      default: s_next.st = ACPC_IDLE;
    endcase
    s_next.ain = sel;
    s_next.conv_rst = (s_next.st != ACPC_RUN);
    s_next.cen = tk.tick && (s_reg.st == ACPC_RUN);
    s_next.irq = s_next.irqf && s_next.irqe;
    // Power and reference come from the register bit's next value, so they change in the same cycle as the bit
    s_next.pwr_on = !s_next.poff;
    s_next.ref_ext = s_next.vref;
  end
  // Divider restarts with each conversion so the first period is whole
  assign tk.div_sel = s_reg.div;
  assign tk.clr = (s_reg.st != ACPC_RUN);
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
      s_reg.sel_low <= ACPC_SEL_LOW_RST;
      s_reg.sel_high <= ACPC_SEL_HIGH_RST;
      s_reg.busy <= ACPC_BUSY_RST;
      s_reg.poff <= ACPC_POFF_RST;
      s_reg.div <= ACPC_DIV_RST;
      s_reg.st <= ACPC_IDLE;
      s_reg.ain <= {ACPC_SEL_HIGH_RST, ACPC_SEL_LOW_RST};
      s_reg.conv_rst <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign prdata_o = s_reg.rdata;
  assign pready_o = s_reg.ready;
  assign pslverr_o = s_reg.err;
  assign analog_input_channels_o = s_reg.ain;
  assign pin_func_disable_o = s_reg.ain;
  assign pull_high_disable_o = s_reg.ain;
  assign dir_override_o = s_reg.ain;
  assign converter_power_on_o = s_reg.pwr_on;
  assign converter_reset_o = s_reg.conv_rst;
  assign conv_clk_en_o = s_reg.cen;
  assign conversion_busy_o = s_reg.busy;
  assign reference_ext_o = s_reg.ref_ext;
  assign vref_pin_func_disable_o = s_reg.ref_ext;
  assign irq_o = s_reg.irq;
endmodule : acpc_ctrl
`default_nettype wire

// ===== acpc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acpc_ctrl_sva (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [9:0] analog_input_channels_o,
  input wire logic [9:0] pull_high_disable_o,
  input wire logic converter_power_on_o,
  input wire logic converter_reset_o,
  input wire logic conv_clk_en_o,
  input wire logic conversion_busy_o,
  input wire logic reference_ext_o,
  input wire logic vref_pin_func_disable_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Wide counter so a runaway conversion cannot wrap back to a legal count
  logic [10:0] cnt;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || converter_reset_o) begin
      cnt <= 11'h0;
    end else if (conv_clk_en_o) begin
      cnt <= cnt + 11'h1;
    end
  end
  sel_same_a: assert property (analog_input_channels_o == pull_high_disable_o)
    else $error("pull-high release differs from select");
  vref_same_a: assert property (reference_ext_o == vref_pin_func_disable_o)
    else $error("reference pin outputs differ");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  ready_lat_a: assert property ($rose(penable_i) |=> pready_o)
    else $error("ready not after one wait state");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside ready");
  // Busy only rises on a start, and the converter must be held in reset then
  start_busy_a: assert property ($rose(conversion_busy_o) |-> converter_reset_o)
    else $error("busy set while converter runs");
  // The sixteenth pulse lands with the busy fall, so fifteen come before it
  conv_len_a: assert property ($fell(conversion_busy_o) |-> conv_clk_en_o && cnt == 11'd15)
    else $error("conversion length wrong");
  done_pwr_a: assert property ($fell(conversion_busy_o) |-> converter_power_on_o)
    else $error("completion while powered off");
  cover property ($fell(conversion_busy_o));
  cover property (pslverr_o);
  cover property ($rose(reference_ext_o));
endmodule : acpc_ctrl_sva
bind acpc_ctrl acpc_ctrl_sva u_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .analog_input_channels_o(analog_input_channels_o), .pull_high_disable_o(pull_high_disable_o),
  .converter_power_on_o(converter_power_on_o), .converter_reset_o(converter_reset_o),
  .conv_clk_en_o(conv_clk_en_o), .conversion_busy_o(conversion_busy_o),
  .reference_ext_o(reference_ext_o), .vref_pin_func_disable_o(vref_pin_func_disable_o));
`default_nettype wire

// ===== acpc_pkg.sv
// Summary of operation
// - Select bit one makes pin analog input
// - Low bits map PB0-3, PE4-6, PB4
// - High bits map PE7 and PB5
// - High register bits 7-2 read zero
// - Start high then low launches conversion
// - Start rising resets converter, sets busy
// - Conversion end clears busy flag automatically
// - Conversion end sets interrupt request flag
// - Conversion clock is system clock divided
// - Converter powered only while power-off is zero
// - Reference select takes external pin, disables others
// - Analog pin loses functions and pull-high
// - Analog select overrides port direction control
// - Busy flag read-only, resets to one
// - Conversion lasts sixteen conversion clock periods
package acpc_pkg;
  localparam logic [11:0] ACPC_OFS_CTRL_FIRST = 12'h000;
  localparam logic [11:0] ACPC_OFS_CTRL_SECOND = 12'h004;
  localparam logic [11:0] ACPC_OFS_SEL_LOW = 12'h008;
  localparam logic [11:0] ACPC_OFS_SEL_HIGH = 12'h00c;
  localparam logic [11:0] ACPC_OFS_IRQ = 12'h010;
  localparam int ACPC_START_POS = 7;
  localparam int ACPC_BUSY_POS = 6;
  localparam int ACPC_POFF_POS = 5;
  localparam int ACPC_VREF_POS = 4;
  localparam int ACPC_DIV_LSB = 0;
  localparam int ACPC_IRQF_POS = 0;
  localparam int ACPC_IRQE_POS = 1;
  localparam logic [7:0] ACPC_SEL_LOW_RST = 8'hff;
  localparam logic [1:0] ACPC_SEL_HIGH_RST = 2'h3;
  localparam logic ACPC_POFF_RST = 1'b1;
  localparam logic ACPC_BUSY_RST = 1'b1;
  localparam logic [2:0] ACPC_DIV_RST = 3'h0;
  localparam logic [5:0] ACPC_DIV_MAX_LIM = 6'h3f;
  localparam logic [4:0] ACPC_CONV_TICKS = 5'h10;
  localparam int ACPC_NPIN = 10;
  typedef enum logic [1:0] {
    ACPC_IDLE = 2'b00,
    ACPC_HOLD = 2'b01,
    ACPC_RUN = 2'b10
  } acpc_state_t;
endpackage : acpc_pkg

// ===== acpc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acpc_tick_if;
  logic [2:0] div_sel;
  logic clr;
  logic tick;
  modport src (input div_sel, input clr, output tick);
  modport snk (output div_sel, output clr, input tick);
endinterface : acpc_tick_if
`default_nettype wire

// ===== test_adc_pin_select_and_conversion_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_pin_select_and_conversion_ctrl;
  import acpc_pkg::*;
  logic mclk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, e, tmo;
  logic pwr, rcv, busy, rext, irq, vpd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:0] sel, pfd, phd, dov;
  int mismatches = 0, checks = 0, n;
  acpc_apb_host u_host (.mclk_i(mclk_i), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  acpc_ctrl u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .analog_input_channels_o(sel),
    .pin_func_disable_o(pfd), .pull_high_disable_o(phd), .dir_override_o(dov),
    .converter_power_on_o(pwr), .converter_reset_o(rcv), .conv_clk_en_o(),
    .conversion_busy_o(busy), .reference_ext_o(rext), .vref_pin_func_disable_o(vpd),
    .irq_o(irq));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  task print_verdict;
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(w, a, d, q, e, tmo);
    if (tmo) begin
      mismatches++;
      $display("Error %0t: no ready", $time);
      print_verdict;
    end
  endtask : xf
  task rd(input logic [11:0] a, input logic [31:0] exp);
    xf(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task pon;
    xf(1'b1, ACPC_OFS_CTRL_FIRST, 32'h0);
    repeat (20) @(posedge mclk_i);
    chk({31'h0, pwr}, 32'h1);
  endtask : pon
  task conv(input logic [2:0] c, input int p);
    xf(1'b1, ACPC_OFS_CTRL_SECOND, 32'h10 + {29'h0, c});
    rd(ACPC_OFS_CTRL_SECOND, 32'h10 + {29'h0, c});
    xf(1'b1, ACPC_OFS_CTRL_FIRST, 32'h80);
    rd(ACPC_OFS_CTRL_FIRST, 32'hc0);
    chk({31'h0, rcv}, 32'h1);
    xf(1'b1, ACPC_OFS_CTRL_FIRST, 32'h0);
    for (n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge mclk_i);
    if (n == 2000) begin
      mismatches++;
      $display("Error %0t: busy never cleared", $time);
      print_verdict;
    end
    chk({31'h0, n >= 16 * p && n <= 16 * p + 4}, 32'h1);
    rd(ACPC_OFS_CTRL_FIRST, 32'h0);
    rd(ACPC_OFS_IRQ, 32'h1);
  endtask : conv
  initial begin
    rst_b_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(ACPC_OFS_CTRL_FIRST, 32'h60);
    rd(ACPC_OFS_SEL_LOW, 32'hff);
    chk({22'h0, sel}, 32'h3ff);
    chk({30'h0, rext, vpd}, 32'h0);
    xf(1'b1, ACPC_OFS_SEL_HIGH, 32'hfe);
    rd(ACPC_OFS_SEL_HIGH, 32'h2);
    xf(1'b1, ACPC_OFS_SEL_LOW, 32'ha5);
    rd(ACPC_OFS_SEL_LOW, 32'ha5);
    chk({22'h0, sel}, 32'h2a5);
    chk({22'h0, pfd}, 32'h2a5);
    chk({22'h0, phd}, 32'h2a5);
    chk({22'h0, dov}, 32'h2a5);
    rd(12'h0ff, 32'h0);
    chk({31'h0, e}, 32'h1);
    pon();
    // Every divider code, 111 included as the slowest
    // At this clock every code is faster than the accurate range; only timing is checked
    for (int k = 0; k < 8; k++) begin
      conv(k[2:0], 1 << (k > 5 ? 6 : k));
      xf(1'b1, ACPC_OFS_IRQ, 32'h1);
    end
    chk({31'h0, rext}, 32'h1);
    chk({31'h0, vpd}, 32'h1);
    xf(1'b1, ACPC_OFS_CTRL_FIRST, 32'h20);
    xf(1'b1, ACPC_OFS_CTRL_FIRST, 32'ha0);
    xf(1'b1, ACPC_OFS_CTRL_FIRST, 32'h20);
    repeat (40) @(posedge mclk_i);
    rd(ACPC_OFS_CTRL_FIRST, 32'h60);
    chk({31'h0, pwr}, 32'h0);
    pon();
    conv(3'h0, 1);
    repeat (3) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    xf(1'b1, ACPC_OFS_IRQ, 32'h2);
    repeat (3) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h1);
    xf(1'b1, ACPC_OFS_IRQ, 32'h3);
    rd(ACPC_OFS_IRQ, 32'h2);
    chk({31'h0, irq}, 32'h0);
    print_verdict;
  end
endmodule : test_adc_pin_select_and_conversion_ctrl
`default_nettype wire
